// file: bench/ccs_bytes_chk.sv
// checker: channel 1 status rules, channel 2 echo; sees block ports only
`timescale 1ns/1ns
`default_nettype none
module ccs_bytes_chk #(parameter CHANNELS = 2, parameter CAL_CYCLES = 256) (
  input wire clk_i, rst_i,
  input wire [8*CHANNELS-1:0] control_byte_i, status_byte_o,
  input wire [16*CHANNELS-1:0] output_data_word_i, process_value_i, input_data_word_o,
  input wire [CHANNELS-1:0] cal_unstable_i, auto_cal_due_i, error_led_o, cal_active_o);
  wire [7:0] c = control_byte_i[7:0];
  wire [7:0] s = status_byte_o[7:0];
  wire k = cal_active_o[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_rd;
    c == 8'hd5 ##1 c == 8'h95;
  endsequence
  a_pd_ack: assert property (!c[7] |=> !s[7]) else $error("pd ack");
  a_reg_ack: assert property (c[7] |=> s[7]) else $error("reg ack");
  a_reg_echo: assert property (c[7] |=> s[6:0] == $past(c[6:0])) else $error("echo");
  a_read_back: assert property (s_wr_rd |=>
    input_data_word_o[15:0] == $past(output_data_word_i[15:0], 2)) else $error("readback");
  a_cal_flags: assert property (!c[7] ##1 k |-> s[1:0] == 2'b11) else $error("cal");
  a_cal_start: assert property (!c[7] && $rose(c[0]) && !k |-> ##2 k) else $error("start");
  a_auto_block: assert property (!c[7] && c[1] && !c[0] && auto_cal_due_i[0] && !k
    |=> !k) else $error("auto");
  a_ch2_echo: assert property (control_byte_i[15] |=>
    status_byte_o[15:8] == $past(control_byte_i[15:8])) else $error("ch2 echo");
endmodule
bind ccs_channel_bytes ccs_bytes_chk #(.CHANNELS(CHANNELS), .CAL_CYCLES(CAL_CYCLES))
  u_chk (.*);
`default_nettype wire

// file: bench/ccs_channel_bytes_tb_top.sv
// bench: coupler model drives channel bytes, tasks judge status
`timescale 1ns/1ns
`default_nettype none
module ccs_channel_bytes_tb_top;
  logic clk_i = 0, rst_i = 1;
  logic [31:0] process_value_i = 0;
  logic [1:0] cal_unstable_i = 0, auto_cal_due_i = 0;
  wire [15:0] control_byte_i, status_byte_o;
  wire [31:0] output_data_word_i, input_data_word_o;
  wire [1:0] error_led_o, cal_active_o;
  int err_count = 0, tests_run = 0;
  logic [15:0] d;
  ccs_channel_bytes #(.CAL_CYCLES(4)) uut (.*);
  ccs_cpl_model u_cpl (.clk_i(clk_i), .sb_i(status_byte_o), .idw_i(input_data_word_o),
    .cb_o(control_byte_i), .odw_o(output_data_word_i));
  initial forever #4 clk_i = ~clk_i;
  task chk(string n, logic [15:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(logic [5:0] n, logic [15:0] v);
    u_cpl.put(0, {2'b11, n}, v);
    u_cpl.put(0, 8'h00, 16'h0);
  endtask
  // led rides along with the range bits
  task probe(logic [15:0] v, logic [7:0] e);
    @(negedge clk_i) process_value_i[15:0] = v;
    @(negedge clk_i) chk("sb", {e[1] | e[0], e}, {error_led_o[0], status_byte_o[7:0]});
  endtask
  task t_regs;
    u_cpl.put(0, 8'hd5, 16'h8000);
    u_cpl.put(1, 8'hd5, 16'h7000);
    u_cpl.rd(0, 6'h15, d);
    chk("r15", 16'h8000, d);
    u_cpl.rd(1, 6'h15, d);
    chk("r15 ch2", 16'h7000, d);
    u_cpl.rd(0, 6'h3f, d);
    chk("r3f", 16'h0, d);
    u_cpl.put(1, 8'h00, 16'h0);
    wr(6'h16, 16'h1000);
    probe(16'h9000, 8'h02);
    probe(16'h0800, 8'h01);
  endtask
  task t_lim;
    wr(6'h20, 16'h0600);
    wr(6'h23, 16'h4000);
    wr(6'h24, 16'h5000);
    probe(16'h4000, 8'h1c);
    probe(16'h6000, 8'h28);
    probe(16'h5000, 8'h38);
  endtask
  task t_cal;
    u_cpl.put(0, 8'h01, 16'h0);
    @(negedge clk_i) cal_unstable_i[0] = 1;
    @(negedge clk_i) cal_unstable_i[0] = 0;
    chk("cal", 16'h7, {cal_active_o[0], status_byte_o[1:0]});
    repeat (6) @(negedge clk_i);
    chk("err", 16'h1, {cal_active_o[0], status_byte_o[6]});
    u_cpl.put(0, 8'h02, 16'h0);
    @(negedge clk_i) auto_cal_due_i[0] = 1;
    @(negedge clk_i) auto_cal_due_i[0] = 0;
    @(negedge clk_i);
    chk("blocked", 16'h0, cal_active_o[0]);
    u_cpl.put(0, 8'h00, 16'h0);
    @(negedge clk_i) auto_cal_due_i[0] = 1;
    @(negedge clk_i) auto_cal_due_i[0] = 0;
    @(negedge clk_i);
    chk("auto", 16'h1, cal_active_o[0]);
    repeat (6) @(negedge clk_i);
    wr(6'h20, 16'h4600);
    probe(16'h9000, 8'h6a);
  endtask
  initial
  begin
    repeat (4) @(negedge clk_i);
    chk("reset", 16'h0, status_byte_o);
    rst_i = 0;
    t_regs;
    t_lim;
    t_cal;
    end_of_test;
  end
  initial
  begin
    #20000;
    err_count++;
    end_of_test;
  end
endmodule
`default_nettype wire

// file: bench/ccs_cpl_model.sv
// coupler model: owns the output image, reads the input image
`timescale 1ns/1ns
`default_nettype none
module ccs_cpl_model (
  input  wire logic        clk_i,      // block clock
  input  wire logic [15:0] sb_i,       // status bytes
  input  wire logic [31:0] idw_i,      // input words
  output logic      [15:0] cb_o = 0,   // control bytes, full image unpadded
  output logic      [31:0] odw_o = 0); // output words
  task put(int ch, logic [7:0] cb, logic [15:0] w);
    @(negedge clk_i);
    cb_o[8*ch+:8] = cb;
    odw_o[16*ch+:16] = w;
  endtask
  // data counts only once the echo matches the request
  task rd(int ch, logic [5:0] n, output logic [15:0] d);
    put(ch, {2'b10, n}, 16'h0);
    d = 'x;
    repeat (3) @(negedge clk_i) if (sb_i[8*ch+:8] === {2'b10, n}) d = idw_i[16*ch+:16];
  endtask
endmodule
`default_nettype wire

// file: hdl/ccs_channel_bytes.v
// two-channel control byte decoder and status byte generator
// assumes process image words arrive synchronous to clk_i each cycle
`timescale 1ns/1ns
`default_nettype none
`include "ccs_map.vh"

// What this block does
// - control byte in, status byte out
// - control bit7 low selects process data mode
// - process mode clears status bit 7
// - auto_calibration_block inhibits automatic calibration
// - manual_calibration_start launches manual calibration
// - error bit: overload/underload or calibration unstable
// - status 5:4 compares against limit 2
// - status 3:2 compares against limit 1
// - above upper_range_limit sets bit1, red LED
// - below lower_range_limit sets bit0, red LED
// - calibration running sets bits 0 and 1
// - control bit7 high selects register mode
// - bit6 chooses read or write direction
// - bits 5:0 register number; read returns content
// - register mode sets status bit 7
// - echo register number and direction
// - channel 2 identical to channel 1
module ccs_channel_bytes #(
  parameter CHANNELS   = 2,
  parameter CAL_CYCLES = `CCS_CAL_CYCLES
) (
  input  wire                  clk_i,          // 125 MHz clock
  input  wire                  rst_i,          // sync reset, active high
  input  wire [8*CHANNELS-1:0] control_byte_i, // per-channel control bytes
  input  wire [16*CHANNELS-1:0] output_data_word_i, // per-channel output words
  input  wire [16*CHANNELS-1:0] process_value_i, // per-channel conversion results
  input  wire [CHANNELS-1:0]   cal_unstable_i, // calibration ended unstable (pulse)
  input  wire [CHANNELS-1:0]   auto_cal_due_i, // automatic calibration request (pulse)
  output wire [8*CHANNELS-1:0] status_byte_o,  // per-channel status bytes
  output wire [16*CHANNELS-1:0] input_data_word_o, // per-channel input words
  output wire [CHANNELS-1:0]   error_led_o,    // red error indicators
  output wire [CHANNELS-1:0]   cal_active_o    // calibration running
);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : ch
      ccs_chan_unit #(
        .CAL_CYCLES (CAL_CYCLES)
      ) u_unit (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .control_byte_i     (control_byte_i[8*g +: 8]),
        .output_data_word_i (output_data_word_i[16*g +: 16]),
        .process_value_i    (process_value_i[16*g +: 16]),
        .cal_unstable_i     (cal_unstable_i[g]),
        .auto_cal_due_i     (auto_cal_due_i[g]),
        .status_byte_o      (status_byte_o[8*g +: 8]),
        .input_data_word_o  (input_data_word_o[16*g +: 16]),
        .error_led_o        (error_led_o[g]),
        .cal_active_o       (cal_active_o[g])
      );
    end
  endgenerate

endmodule

// one channel: decoder, parameter set, calibration timer, status byte
module ccs_chan_unit #(
  parameter CAL_CYCLES = `CCS_CAL_CYCLES
) (
  input  wire        clk_i,              // block clock
  input  wire        rst_i,              // sync reset, active high
  input  wire [7:0]  control_byte_i,     // this channel's control byte
  input  wire [15:0] output_data_word_i, // this channel's output word
  input  wire [15:0] process_value_i,    // conversion result
  input  wire        cal_unstable_i,     // calibration ended unstable
  input  wire        auto_cal_due_i,     // automatic calibration wanted
  output wire [7:0]  status_byte_o,      // status byte
  output wire [15:0] input_data_word_o,  // input word
  output wire        error_led_o,        // red error indicator
  output wire        cal_active_o        // calibration running
);

  wire        reg_mode;
  wire        is_write;
  wire [5:0]  reg_num;
  wire        man_bit;
  wire        blk_bit;
  wire [15:0] upper_q;
  wire [15:0] lower_q;
  wire [15:0] feature_q;
  wire [15:0] limit1_q;
  wire [15:0] limit2_q;
  wire [1:0]  lim1_state;
  wire [1:0]  lim2_state;
  wire        wr_en;
  wire        over;
  wire        under;
  wire        cal_run;
  wire        man_req;
  wire        auto_ok;
  wire        err_bit;

  reg  [15:0] cal_cnt_r;
  reg  [15:0] cal_cnt_nxt;
  reg         cal_err_r;
  reg         cal_err_nxt;
  reg         man_prev_r;
  reg  [7:0]  status_r;
  reg  [7:0]  status_nxt;
  reg  [15:0] word_r;
  reg  [15:0] word_nxt;
  reg         led_r;
  reg         cal_act_r;
  reg  [15:0] rd_data;

  assign reg_mode = control_byte_i[`CCS_CB_REG_MODE];
  assign is_write = control_byte_i[`CCS_CB_WRITE];
  assign reg_num  = control_byte_i[5:0];
  assign man_bit  = control_byte_i[`CCS_CB_MAN_CAL];
  assign blk_bit  = control_byte_i[`CCS_CB_AUTO_BLOCK];
  assign wr_en    = reg_mode && is_write;
  assign over     = process_value_i > upper_q;
  assign under    = process_value_i < lower_q;
  assign cal_run  = cal_cnt_r != 16'h0000;
  // edge on the request bit so a held bit does not loop calibration
  assign man_req  = !reg_mode && man_bit && !man_prev_r;
  assign auto_ok  = auto_cal_due_i && !blk_bit;
  assign err_bit  = feature_q[`CCS_FEAT_ERR_SEL] ? (over || under) : cal_err_r;

  // small parameter set; other numbers read as zero, writes ignored
  ccs_param_reg #(
    .ADDR (`CCS_UPPER_LIMIT),
    .RST  (`CCS_UPPER_RST)
  ) u_upper (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .we_i  (wr_en),
    .num_i (reg_num),
    .d_i   (output_data_word_i),
    .q_o   (upper_q)
  );

  ccs_param_reg #(
    .ADDR (`CCS_LOWER_LIMIT),
    .RST  (`CCS_LOWER_RST)
  ) u_lower (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .we_i  (wr_en),
    .num_i (reg_num),
    .d_i   (output_data_word_i),
    .q_o   (lower_q)
  );

  ccs_param_reg #(
    .ADDR (`CCS_FEATURE_REG),
    .RST  (`CCS_PARAM_RST)
  ) u_feature (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .we_i  (wr_en),
    .num_i (reg_num),
    .d_i   (output_data_word_i),
    .q_o   (feature_q)
  );

  ccs_param_reg #(
    .ADDR (`CCS_LIMIT1_REG),
    .RST  (`CCS_PARAM_RST)
  ) u_limit1 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .we_i  (wr_en),
    .num_i (reg_num),
    .d_i   (output_data_word_i),
    .q_o   (limit1_q)
  );

  ccs_param_reg #(
    .ADDR (`CCS_LIMIT2_REG),
    .RST  (`CCS_PARAM_RST)
  ) u_limit2 (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .we_i  (wr_en),
    .num_i (reg_num),
    .d_i   (output_data_word_i),
    .q_o   (limit2_q)
  );

  ccs_limit_cmp u_lim1 (
    .en_i    (feature_q[`CCS_FEAT_LIM1_EN]),
    .value_i (process_value_i),
    .limit_i (limit1_q),
    .state_o (lim1_state)
  );

  ccs_limit_cmp u_lim2 (
    .en_i    (feature_q[`CCS_FEAT_LIM2_EN]),
    .value_i (process_value_i),
    .limit_i (limit2_q),
    .state_o (lim2_state)
  );

  always @*
  begin
    case (reg_num)
      `CCS_UPPER_LIMIT: rd_data = upper_q;
      `CCS_LOWER_LIMIT: rd_data = lower_q;
      `CCS_FEATURE_REG: rd_data = feature_q;
      `CCS_LIMIT1_REG:  rd_data = limit1_q;
      `CCS_LIMIT2_REG:  rd_data = limit2_q;
      default:          rd_data = 16'h0000;
    endcase
  end

  // a running calibration is never restarted by a new request
  always @*
  begin
    cal_cnt_nxt = cal_cnt_r;
    cal_err_nxt = cal_err_r;
    if (!cal_run && (man_req || auto_ok))
    begin
      cal_cnt_nxt = CAL_CYCLES[15:0];
      cal_err_nxt = 1'b0;
    end
    else if (cal_run)
    begin
      cal_cnt_nxt = cal_cnt_r - 16'h0001;
    end
    // set wins over the clear of a restart in the same cycle
    if (cal_unstable_i)
    begin
      cal_err_nxt = 1'b1;
    end
  end

  always @*
  begin
    if (reg_mode)
    begin
      status_nxt = {1'b1, is_write, reg_num};
      word_nxt   = rd_data;
    end
    else
    begin
      status_nxt = {1'b0, err_bit, lim2_state, lim1_state,
                    over || cal_run, under || cal_run};
      word_nxt   = process_value_i;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cal_cnt_r  <= 16'h0000;
      cal_err_r  <= 1'b0;
      man_prev_r <= 1'b0;
      status_r   <= 8'h00;
      word_r     <= 16'h0000;
      led_r      <= 1'b0;
      cal_act_r  <= 1'b0;
    end
    else
    begin
      man_prev_r <= !reg_mode && man_bit;
      cal_cnt_r  <= cal_cnt_nxt;
      cal_err_r  <= cal_err_nxt;
      status_r   <= status_nxt;
      word_r     <= word_nxt;
      led_r      <= over || under;
      cal_act_r  <= cal_run;
    end
  end

  assign status_byte_o     = status_r;
  assign input_data_word_o = word_r;
  assign error_led_o       = led_r;
  assign cal_active_o      = cal_act_r;

endmodule

// one parameter register, answering to a single register number
module ccs_param_reg #(
  parameter [5:0]  ADDR = 6'h00,
  parameter [15:0] RST  = 16'h0000
) (
  input  wire        clk_i, // block clock
  input  wire        rst_i, // sync reset, active high
  input  wire        we_i,  // register write request
  input  wire [5:0]  num_i, // requested register number
  input  wire [15:0] d_i,   // write data
  output wire [15:0] q_o    // stored value
);

  reg [15:0] value_r;

  // a held write byte rewrites every cycle, harmless for a level image
  always @(posedge clk_i)
  begin
    if (rst_i)
      value_r <= RST;
    else if (we_i && (num_i == ADDR))
      value_r <= d_i;
  end

  assign q_o = value_r;

endmodule

// limit comparison code for one limit value
module ccs_limit_cmp (
  input  wire        en_i,    // comparison enabled
  input  wire [15:0] value_i, // process value
  input  wire [15:0] limit_i, // limit value
  output reg  [1:0]  state_o  // compare state code
);

  always @*
  begin
    if (!en_i)
      state_o = `CCS_CMP_OFF;
    else if (value_i < limit_i)
      state_o = `CCS_CMP_BELOW;
    else if (value_i > limit_i)
      state_o = `CCS_CMP_ABOVE;
    else
      state_o = `CCS_CMP_EQUAL;
  end

endmodule
`default_nettype wire

// file: hdl/ccs_map.vh
// constants for the channel control/status byte block
// assumes inclusion by bare name from the design file
`ifndef CCS_MAP_VH
`define CCS_MAP_VH
`define CCS_CB_REG_MODE     7
`define CCS_CB_WRITE        6
`define CCS_CB_AUTO_BLOCK   1
`define CCS_CB_MAN_CAL      0
`define CCS_SB_ACK          7
`define CCS_SB_ERR          6
`define CCS_SB_LIM2_HI      5
`define CCS_SB_LIM2_LO      4
`define CCS_SB_LIM1_HI      3
`define CCS_SB_LIM1_LO      2
`define CCS_SB_OVER         1
`define CCS_SB_UNDER        0
`define CCS_REG_NUM_W       6
`define CCS_UPPER_LIMIT     6'h15
`define CCS_LOWER_LIMIT     6'h16
`define CCS_FEATURE_REG     6'h20
`define CCS_FEAT_ERR_SEL    14
`define CCS_FEAT_LIM2_EN    10
`define CCS_FEAT_LIM1_EN    9
`define CCS_LIMIT1_REG      6'h23
`define CCS_LIMIT2_REG      6'h24
`define CCS_UPPER_RST       16'hffff
`define CCS_LOWER_RST       16'h0000
`define CCS_PARAM_RST       16'h0000
`define CCS_CMP_OFF         2'h0
`define CCS_CMP_BELOW       2'h1
`define CCS_CMP_ABOVE       2'h2
`define CCS_CMP_EQUAL       2'h3
`define CCS_CAL_CYCLES      16'h0100
`endif
